// file: hw/vch_pkg.sv
// Purpose: shared constants and types of the two-wire converter-code host
// Assumes: clk_sys at 200 MHz; one master on the bus
// Notes:   bus phase lengths keep the serial clock at 400 kHz or below
package vch_pkg;
  localparam int CLK_MHZ     = 200;
  localparam int CODE_W      = 7;
  localparam int SLOT_NUM    = 30;
  localparam int CNT_W       = 9;
  // serial clock phases and bus free, ns; burn interval, ms
  localparam int SCL_LOW_NS  = 1500;
  localparam int SCL_HIGH_NS = 1000;
  localparam int BUS_FREE_NS = 1300;
  localparam int BURN_MS     = 500;
  // least times round up
  localparam int HALF_CYC    = (SCL_LOW_NS * CLK_MHZ + 1999) / 2000;
  localparam int HIGH_CYC    = (SCL_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int BUF_CYC     = (BUS_FREE_NS * CLK_MHZ + 999) / 1000;
  localparam int BURN_CYC    = BURN_MS * CLK_MHZ * 1000;
  // address byte
  localparam logic [6:0] DEV_ADDR = 7'h4F;
  localparam logic       DIR_WR   = 1'h0;
  localparam logic       DIR_RD   = 1'h1;
  // data byte target bit
  localparam logic       TGT_FUSE = 1'h0;
  localparam logic       TGT_LIVE = 1'h1;
  // user commands
  localparam logic [1:0] CMD_LIVE = 2'h0;
  localparam logic [1:0] CMD_BURN = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [4:0] SLOT_MAX = 5'h1E;
  typedef enum logic [1:0] {VCH_BOP_START, VCH_BOP_BIT, VCH_BOP_STOP} vch_bop_t;
endpackage

// file: hw/vch_bit_if.sv
// Purpose: carrier between the byte sequencer and the bit engine
// Assumes: single clock domain
// Notes:   req is a one-cycle pulse; done answers it once
`timescale 1ns/10ps
interface vch_bit_if;
  logic              req;
  vch_pkg::vch_bop_t op;
  logic              wbit;
  logic              sda_in;
  logic              done;
  logic              rbit;
  logic              scl;
  logic              sda_oe;
  modport ctl (output req, op, wbit, sda_in, input done, rbit, scl, sda_oe);
  modport eng (input req, op, wbit, sda_in, output done, rbit, scl, sda_oe);
endinterface

// file: hw/vch_bit_eng.sv
// Purpose: bit-level engine making start, stop and data bit waveforms
// Assumes: sda_in already synchronised; no clock stretching by the slave
// Notes:   pin levels follow the phase one cycle late, which is harmless
`timescale 1ns/10ps
module vch_bit_eng (
  input wire logic clk_sys,
  input wire logic reset,
  vch_bit_if.eng   bus
);
  logic              busy_q;
  vch_pkg::vch_bop_t op_q;
  logic              wbit_q;
  logic [1:0]        ph_q;
  logic [8:0]        cnt_q;
  logic              scl_q;
  logic              oe_q;
  logic              done_q;
  logic              rbit_q;
  logic [8:0]        dur;
  logic              scl_n;
  logic              low_n;

  always_comb begin
    dur   = 9'(vch_pkg::HALF_CYC);
    scl_n = 1'b1;
    low_n = 1'b0;
    case (op_q)
      // start: sda falls with scl high
      vch_pkg::VCH_BOP_START: begin
        scl_n = (ph_q != 2'h2);
        low_n = (ph_q != 2'h0);
        if (ph_q == 2'h1) begin
          dur = 9'(vch_pkg::HIGH_CYC);
        end
      end
      // one bit per clock, sda steady while high
      vch_pkg::VCH_BOP_BIT: begin
        scl_n = (ph_q == 2'h1);
        low_n = ~wbit_q;
        if (ph_q == 2'h1) begin
          dur = 9'(vch_pkg::HIGH_CYC);
        end
      end
      // stop: sda rises with scl high, then bus free
      vch_pkg::VCH_BOP_STOP: begin
        scl_n = (ph_q != 2'h0);
        low_n = (ph_q != 2'h2);
        if (ph_q == 2'h1) begin
          dur = 9'(vch_pkg::HIGH_CYC);
        end else if (ph_q == 2'h2) begin
          dur = 9'(vch_pkg::BUF_CYC);
        end
      end
      default: begin
        scl_n = 1'b1;
        low_n = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_q <= 1'b0;
      op_q   <= vch_pkg::VCH_BOP_STOP;
      wbit_q <= 1'b1;
      ph_q   <= 2'h0;
      cnt_q  <= 9'h000;
      done_q <= 1'b0;
      rbit_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && bus.req) begin
        busy_q <= 1'b1;
        op_q   <= bus.op;
        wbit_q <= bus.wbit;
        ph_q   <= 2'h0;
        cnt_q  <= 9'h000;
      end else if (busy_q) begin
        if (cnt_q == dur - 9'h001) begin
          cnt_q <= 9'h000;
          if (ph_q == 2'h1) begin
            rbit_q <= bus.sda_in;
          end
          if (ph_q == 2'h2) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            ph_q <= ph_q + 2'h1;
          end
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
      end
    end
  end

  // the master alone makes the clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_q <= 1'b1;
      oe_q  <= 1'b0;
    end else if (busy_q) begin
      scl_q <= scl_n;
      oe_q  <= low_n;
    end
  end

  assign bus.done   = done_q;
  assign bus.rbit   = rbit_q;
  assign bus.scl    = scl_q;
  assign bus.sda_oe = oe_q;
endmodule

// file: hw/vch_host.sv
// Purpose: two-wire bus master that sets, burns and reads a 7-bit converter code
// Assumes: one command at a time; device at fixed address; single master
// Notes:   burn commands stall in a hold state while the burn interval runs
//
// Operation
// - host waits 500 ms after an accepted burn before the next burn
// - serial clock stays at or below 400 kHz
// - master drives the clock and starts every transfer
// - each transfer is start, address, data, stop, or start, address, stop when the address is not acknowledged
// - 8-bit words each followed by an acknowledge clock
// - read: address, then nine clocks while slave shifts data out
// - master reads a single byte and ends with not-acknowledge and stop
// - one bit per clock, sda stable while clock is high
// - both lines released high while idle
// - master never stops in the same high pulse as the start
// - first byte is 7-bit address then direction, 1 read
`timescale 1ns/10ps
module vch_host #(
  parameter int BURN_CYC = vch_pkg::BURN_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_op,
  input  wire logic [6:0] cmd_code,
  output logic            rsp_valid,
  output logic            rsp_ack,
  output logic [6:0]      rsp_code,
  output logic            burn_wait,
  output logic [4:0]      burn_count,
  output logic            scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);
  localparam int TW = $clog2(BURN_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD, ST_START, ST_ADDR, ST_WDATA, ST_RDATA, ST_STOP, ST_RESP
  } vch_st_t;

  vch_bit_if bus ();

  vch_st_t           st_q;
  logic [1:0]        op_q;
  logic [6:0]        code_q;
  logic [7:0]        shift_q;
  logic [3:0]        bitn_q;
  logic              ack_ok_q;
  logic              issued_q;
  logic              req_q;
  vch_pkg::vch_bop_t bop_q;
  logic              wbit_q;
  logic              ready_q;
  logic              rsp_valid_q;
  logic              rsp_ack_q;
  logic [6:0]        rsp_code_q;
  logic [TW-1:0]     wait_q;
  logic              wait_busy_q;
  logic [4:0]        slots_q;
  logic              sda_m_q;
  logic              sda_s_q;
  logic              sda_o_q;
  vch_pkg::vch_bop_t bop_d;
  logic              wbit_d;
  logic              burn_go;

  // two flops before the pin is used
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  // open drain: only ever drive low
  always_ff @(posedge clk_sys) begin
    sda_o_q <= 1'b0;
  end

  always_comb begin
    bop_d  = vch_pkg::VCH_BOP_BIT;
    wbit_d = 1'b1;
    case (st_q)
      ST_START: begin
        bop_d = vch_pkg::VCH_BOP_START;
      end
      // eight bits then a released acknowledge bit
      ST_ADDR, ST_WDATA: begin
        wbit_d = (bitn_q == vch_pkg::ACK_BIT) ? 1'b1 : shift_q[7];
      end
      // release during data and on the ninth clock
      ST_RDATA: begin
        wbit_d = 1'b1;
      end
      ST_STOP: begin
        bop_d = vch_pkg::VCH_BOP_STOP;
      end
      default: begin
        wbit_d = 1'b1;
      end
    endcase
  end

  assign burn_go = (st_q == ST_WDATA) && issued_q && bus.done &&
                   (bitn_q == vch_pkg::ACK_BIT) && !bus.rbit && (op_q == vch_pkg::CMD_BURN);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q        <= ST_IDLE;
      op_q        <= vch_pkg::CMD_LIVE;
      code_q      <= 7'h00;
      shift_q     <= 8'hFF;
      bitn_q      <= 4'h0;
      ack_ok_q    <= 1'b0;
      issued_q    <= 1'b0;
      req_q       <= 1'b0;
      bop_q       <= vch_pkg::VCH_BOP_STOP;
      wbit_q      <= 1'b1;
      ready_q     <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_ack_q   <= 1'b0;
      rsp_code_q  <= 7'h00;
    end else begin
      req_q       <= 1'b0;
      rsp_valid_q <= 1'b0;
      if (st_q != ST_IDLE && st_q != ST_HOLD && st_q != ST_RESP && !issued_q) begin
        req_q    <= 1'b1;
        issued_q <= 1'b1;
        bop_q    <= bop_d;
        wbit_q   <= wbit_d;
      end
      case (st_q)
        ST_IDLE: begin
          ready_q <= 1'b1;
          if (cmd_valid && ready_q) begin
            ready_q <= 1'b0;
            op_q    <= cmd_op;
            code_q  <= cmd_code;
            st_q    <= ST_HOLD;
          end
        end
        // no burn until the interval has run out
        ST_HOLD: begin
          if (!(op_q == vch_pkg::CMD_BURN && wait_busy_q)) begin
            st_q <= ST_START;
          end
        end
        ST_START: begin
          if (issued_q && bus.done) begin
            issued_q <= 1'b0;
            shift_q  <= {vch_pkg::DEV_ADDR,
                         (op_q == vch_pkg::CMD_READ) ? vch_pkg::DIR_RD : vch_pkg::DIR_WR};
            bitn_q   <= 4'h0;
            ack_ok_q <= 1'b1;
            st_q     <= ST_ADDR;
          end
        end
        ST_ADDR, ST_WDATA: begin
          if (issued_q && bus.done) begin
            issued_q <= 1'b0;
            if (bitn_q == vch_pkg::ACK_BIT) begin
              bitn_q <= 4'h0;
              // low on the ninth clock means acknowledged
              if (bus.rbit) begin
                ack_ok_q <= 1'b0;
                st_q     <= ST_STOP;
              end else if (st_q == ST_WDATA) begin
                st_q <= ST_STOP;
              end else if (op_q == vch_pkg::CMD_READ) begin
                st_q <= ST_RDATA;
              end else begin
                // code in upper bits, target in bit 0
                shift_q <= {code_q,
                            (op_q == vch_pkg::CMD_BURN) ? vch_pkg::TGT_FUSE : vch_pkg::TGT_LIVE};
                st_q    <= ST_WDATA;
              end
            end else begin
              shift_q <= {shift_q[6:0], 1'b1};
              bitn_q  <= bitn_q + 4'h1;
            end
          end
        end
        // nine clocks: eight data, one not-acknowledge
        ST_RDATA: begin
          if (issued_q && bus.done) begin
            issued_q <= 1'b0;
            if (bitn_q == vch_pkg::ACK_BIT) begin
              // keep upper seven, drop undefined low bit
              rsp_code_q <= shift_q[7:1];
              st_q       <= ST_STOP;
            end else begin
              shift_q <= {shift_q[6:0], bus.rbit};
              bitn_q  <= bitn_q + 4'h1;
            end
          end
        end
        // stop only after at least one full byte clocked
        ST_STOP: begin
          if (issued_q && bus.done) begin
            issued_q <= 1'b0;
            st_q     <= ST_RESP;
          end
        end
        ST_RESP: begin
          rsp_valid_q <= 1'b1;
          rsp_ack_q   <= ack_ok_q;
          st_q        <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // burn interval starts on an acknowledged burn byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_q      <= '0;
      wait_busy_q <= 1'b0;
    end else if (burn_go) begin
      wait_q      <= TW'(BURN_CYC - 1);
      wait_busy_q <= 1'b1;
    end else if (wait_q != '0) begin
      wait_q <= wait_q - TW'(1);
    end else begin
      wait_busy_q <= 1'b0;
    end
  end

  // slots used as seen from this side, saturating at the device limit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slots_q <= 5'h00;
    end else if (burn_go && slots_q != vch_pkg::SLOT_MAX) begin
      slots_q <= slots_q + 5'h01;
    end
  end

  assign bus.req    = req_q;
  assign bus.op     = bop_q;
  assign bus.wbit   = wbit_q;
  assign bus.sda_in = sda_s_q;

  // phase lengths keep the clock at or below 400 kHz
  vch_bit_eng u_eng (
    .clk_sys (clk_sys),
    .reset   (reset),
    .bus     (bus.eng)
  );

  assign cmd_ready  = ready_q;
  assign rsp_valid  = rsp_valid_q;
  assign rsp_ack    = rsp_ack_q;
  assign rsp_code   = rsp_code_q;
  assign burn_wait  = wait_busy_q;
  assign burn_count = slots_q;
  assign scl        = bus.scl;
  assign sda_o      = sda_o_q;
  assign sda_oe     = bus.sda_oe;
endmodule

// file: bench/vch_host_assertions.sv
// Purpose: bus-side checks of the converter-code host
// Assumes: bound to vch_host; one clock domain
// Notes:   hi_q, lo_q and gap_q saturate so long idle spans stay cheap; rise_q wraps
`timescale 1ns/10ps
module vch_host_chk #(
  parameter int BURN_CYC = 2000
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic       rsp_valid,
  input wire logic       rsp_ack,
  input wire logic       burn_wait,
  input wire logic       scl,
  input wire logic       sda_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic       scl_q, oe_q, bw_q;
  logic [1:0] op_q;
  logic [4:0] rise_q;
  int         hi_q, lo_q, gap_q;
  wire        take = cmd_valid && cmd_ready;
  wire        rise = scl && !scl_q;
  wire        strt = scl && sda_oe && !oe_q;
  wire [7:0]  adr  = {vch_pkg::DEV_ADDR, op_q == vch_pkg::CMD_READ};
  always_ff @(posedge clk_sys) begin
    scl_q <= scl;
    oe_q <= sda_oe;
    bw_q <= burn_wait;
    if (reset) begin
      hi_q <= 0;
      lo_q <= 0;
      gap_q <= BURN_CYC;
      rise_q <= 5'h00;
      op_q <= 2'h0;
    end else begin
      hi_q <= scl ? hi_q + int'(hi_q < 999) : 0;
      lo_q <= scl ? 0 : lo_q + int'(lo_q < 999);
      // gap counts from the start of the last burn interval
      gap_q <= (burn_wait && !bw_q) ? 0 : gap_q + int'(gap_q < BURN_CYC);
      if (take) begin
        op_q <= cmd_op;
        rise_q <= 5'h00;
      end else if (rise) begin
        rise_q <= rise_q + 5'h01;
      end
    end
  end
  idle_lines_a: assert property (cmd_ready |-> scl && !sda_oe)
    else $error("bus not released while ready");
  scl_high_a: assert property ($fell(scl) |-> hi_q >= 120)
    else $error("clock high phase too short");
  scl_low_a: assert property ($rose(scl) |-> lo_q >= 260)
    else $error("clock low phase too short");
  start_after_take_a: assert property (take && !burn_wait |-> ##[1:400] (scl && sda_oe))
    else $error("no start after command");
  start_no_stop_a: assert property (strt |-> sda_oe throughout (##[1:400] !scl))
    else $error("stop inside start pulse");
  clock_count_a: assert property (rsp_valid |-> rise_q == 19 || (rise_q == 10 && !rsp_ack))
    else $error("wrong clock count in transfer");
  addr_bits_a: assert property (rise && rise_q < 8 |-> sda_oe == !adr[3'(5'h07 - rise_q)])
    else $error("address bit wrong");
  ack_release_a: assert property (rise && (rise_q == 8 || rise_q == 17) |-> !sda_oe)
    else $error("line held on acknowledge clock");
  burn_gap_a: assert property (strt && op_q == vch_pkg::CMD_BURN |-> gap_q >= BURN_CYC)
    else $error("burn started inside interval");
endmodule
bind vch_host vch_host_chk #(.BURN_CYC(BURN_CYC)) i_vch_host_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .cmd_op(cmd_op),
  .rsp_valid(rsp_valid),
  .rsp_ack(rsp_ack),
  .burn_wait(burn_wait),
  .scl(scl),
  .sda_oe(sda_oe)
);

// file: bench/vch_dev_model.sv
// Purpose: behavioural converter-code device on the two-wire bus
// Assumes: sampled on clk_sys; a released line reads high by pull-up
// Notes:   slot count and burn time are parameters to keep runs short
`timescale 1ns/10ps
module vch_dev_model #(
  parameter int SLOT_N = 30,
  parameter int BURN_N = 2000
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            pull,
  output logic [6:0]      live
);
  logic [6:0] slot [30];
  int         used = 0;
  int         tmr, cnt, nb;
  logic       scl_q, sda_q, act, rdx, ok;
  logic [7:0] sh;
  always @(posedge clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
    if (tmr > 0) tmr <= tmr - 1;
    if (reset) begin
      live <= used > 0 ? slot[used - 1] : 7'h40;
      act <= 1'b0;
      pull <= 1'b0;
      tmr <= 0;
    end else if (scl && scl_q && sda != sda_q) begin
      act <= !sda;
      pull <= 1'b0;
      rdx <= 1'b0;
      cnt <= 0;
      nb <= 0;
    end else if (act && scl && !scl_q) begin
      if (cnt < 8) sh <= {sh[6:0], sda};
      cnt <= cnt + 1;
    end else if (act && !scl && scl_q) begin
      if (cnt == 9) begin
        rdx <= rdx || (nb == 0 && sh[0]);
        pull <= nb == 0 && sh[0] && !live[6];
        cnt <= 0;
        nb <= nb + 1;
      end else if (rdx) begin
        pull <= cnt < 7 && !live[6 - cnt];
      end else if (cnt == 8) begin
        ok = nb == 0 && sh[7:1] == 7'h4F;
        if (nb == 1 && sh[0]) begin
          ok = 1'b1;
          live <= sh[7:1];
        end
        // burn gated by timer and slots
        if (nb == 1 && !sh[0] && tmr == 0 && used < SLOT_N) begin
          ok = 1'b1;
          slot[used] <= sh[7:1];
          used <= used + 1;
          tmr <= BURN_N;
        end
        pull <= ok;
        act <= ok;
      end
    end
  end
endmodule

// file: bench/tb_vch_host.sv
// Purpose: self-checking bench for the converter-code host
// Assumes: device model shares the open-drain data line
// Notes:   two slots and a short burn keep the full-store case brief
`timescale 1ns/10ps
module tb_vch_host;
  localparam int BURN  = 2000;
  localparam int SLOTS = 2;
  logic       clk_sys   = 1'b0;
  logic       reset     = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op    = 2'h0;
  logic [6:0] cmd_code  = 7'h00;
  logic       cmd_ready, rsp_valid, rsp_ack, burn_wait, scl, sda_o, sda_oe, pull;
  logic [6:0] rsp_code, live, b;
  logic [4:0] burn_count;
  wire        sda_w     = !(sda_oe || pull);
  int         bad_count = 0;
  int         n_tests   = 0;
  vch_host #(.BURN_CYC(BURN)) i_vch_host (
    .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_code(cmd_code),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_code(rsp_code),
    .burn_wait(burn_wait), .burn_count(burn_count), .scl(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  vch_dev_model #(.SLOT_N(SLOTS), .BURN_N(BURN)) i_vch_dev_model (
    .clk_sys(clk_sys), .reset(reset), .scl(scl), .sda(sda_w),
    .pull(pull), .live(live)
  );
  function automatic logic fuse_ok(int n);
    return n < SLOTS;
  endfunction
  function automatic logic [6:0] power_code(int n, logic [6:0] last);
    return n > 0 ? last : 7'h40;
  endfunction
  task automatic check(logic [6:0] got, logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic run(logic [1:0] op, logic [6:0] code);
    int i;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_code = code;
    for (i = 0; i < 99 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    // a host that never offers ready ends the run as a failure
    if (cmd_ready !== 1'b1) begin
      bad_count++;
      stop_test;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (i = 0; i < 16000 + BURN && rsp_valid !== 1'b1; i++) @(negedge clk_sys);
    if (rsp_valid !== 1'b1) begin
      bad_count++;
      stop_test;
    end
  endtask
  initial forever #2.5 clk_sys = !clk_sys;
  initial begin
    void'($urandom(32'hD0B2));
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    run(vch_pkg::CMD_READ, 7'h00);
    check(7'(rsp_ack), 7'h01);
    check(rsp_code, power_code(0, 7'h00));
    check(7'(sda_o), 7'h00);
    run(vch_pkg::CMD_LIVE, 7'h7F);
    check(live, 7'h7F);
    check(7'(rsp_ack), 7'h01);
    run(vch_pkg::CMD_BURN, 7'h00);
    check(7'(rsp_ack), 7'(fuse_ok(0)));
    check(7'(burn_wait), 7'h01);
    b = 7'($urandom);
    run(vch_pkg::CMD_BURN, b);
    check(7'(rsp_ack), 7'(fuse_ok(1)));
    run(vch_pkg::CMD_BURN, ~b);
    check(7'(rsp_ack), 7'(fuse_ok(2)));
    check(7'(burn_count), 7'h02);
    run(vch_pkg::CMD_READ, 7'h00);
    check(rsp_code, 7'h7F);
    check(7'(sda_o), 7'h00);
    reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    run(vch_pkg::CMD_READ, 7'h00);
    check(rsp_code, power_code(2, b));
    stop_test;
  end
endmodule
